// *** pbfc_converter.sv ***
// Decimal load/store converter and general-register digit checker.
// Assumes the load/store path presents one operand at a time and waits for done.
`timescale 1ns/1ps
// Contract
// - digits are nibbles valued zero to nine
// - unpacked digit value is low nibble
// - unpacked high nibble zero for multiply/divide
// - packed byte high nibble more significant
// - eighteen digits, least significant in byte zero
// - top bit sign, other seven ignored
// - negatives are sign-magnitude, not complement
// - range plus/minus ten to eighteenth less one
// - load converts exactly to extended format
// - masked invalid store writes indefinite pattern
// - sign bit zero positive, one negative
// - significand is integer bit plus fraction
// - exponent is power of two
// - normalize shifting zeros, decrementing exponent
// - single bias 127
// - double bias 1023, extended 16383
// - extended integer bit 63, fraction 62
module pbfc_converter
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        loadStart,
    input  wire logic [79:0] loadOperand,
    input  wire logic        storeStart,
    input  wire logic        storeInvalid,
    input  wire logic        storeSign,
    input  wire logic [63:0] storeMagnitude,
    input  wire logic [7:0]  gpByte,
    input  wire logic        gpMulDiv,
    output logic             busy,
    output logic             loadDone,
    output logic      [79:0] loadResult,
    output logic             storeDone,
    output logic      [79:0] storeResult,
    output logic      [3:0]  gpHighDigit,
    output logic      [3:0]  gpLowDigit,
    output logic             gpUnpackedOk,
    output logic             gpPackedOk
);
    pbfc_pkg::pbfc_state_t state;
    pbfc_pkg::pbfc_state_t next_state;

    logic [79:0] operand;
    logic        opSign;
    logic [63:0] acc;
    logic [4:0]  digitIdx;
    logic [71:0] bcdShift;
    logic [63:0] binShift;
    logic [6:0]  bitCnt;

    // Digit pick, most significant first; nibble 0 of byte 0 is least significant
    wire  [3:0]  curDigit = operand[digitIdx * pbfc_pkg::DIGIT_W +: pbfc_pkg::DIGIT_W];
    // acc*10 as shifts; bad digits just feed through undetected
    wire  [63:0] accTimes = (acc << 3) + (acc << 1);
    wire  [63:0] accNext  = accTimes + {60'h0, curDigit};
    wire         lastDig  = (digitIdx == '0);

    // Normalizer over the accumulated binary magnitude
    logic [63:0] normSig;
    logic [5:0]  normLz;
    logic        normZero;
    pbfc_normalizer #(.WIDTH(pbfc_pkg::BIN_W), .LZW(pbfc_pkg::LZ_W)) uNorm
    (
        .magnitude (acc),
        .shifted   (normSig),
        .leadZeros (normLz),
        .isZero    (normZero)
    );

    // Biased exponent: bias plus power of the top set bit
    wire  [14:0] normExp = pbfc_pkg::EXT_BIAS + pbfc_pkg::EXT_TOP_POW
                         - {9'h000, normLz};
    // Zero keeps its sign with exponent and significand cleared
    wire  [79:0] extWord = normZero ? {opSign, 79'h0}
                         : {opSign, normExp, normSig[pbfc_pkg::EXT_INT_BIT],
                            normSig[pbfc_pkg::EXT_FRAC_MSB:0]};

    // Double-dabble correction, one adder per digit
    logic [71:0] bcdAdj;
    genvar g;
    generate
        for (g = 0; g < pbfc_pkg::DEC_DIGITS; g++)
        begin : gDabble
            wire [3:0] nib = bcdShift[g * pbfc_pkg::DIGIT_W +: pbfc_pkg::DIGIT_W];
            assign bcdAdj[g * pbfc_pkg::DIGIT_W +: pbfc_pkg::DIGIT_W] =
                (nib >= pbfc_pkg::DABBLE_LIM) ? nib + pbfc_pkg::DABBLE_ADD : nib;
        end
    endgenerate
    wire  [71:0] bcdNext   = {bcdAdj[70:0], binShift[63]};
    wire         storeBad  = storeInvalid || (storeMagnitude > pbfc_pkg::DEC_MAX);
    wire         storeLast = (bitCnt == pbfc_pkg::STORE_LAST);

    // General-register digit checks
    wire         lowOk  = (gpByte[3:0] <= pbfc_pkg::DIGIT_MAX);
    wire         highOk = (gpByte[7:4] <= pbfc_pkg::DIGIT_MAX);
    wire         highZ  = (gpByte[7:4] == 4'h0);

    // Sequencer; a load wins over a store offered in the same cycle
    always_comb
    begin
        next_state = state;
        unique case (state)
            pbfc_pkg::ST_IDLE:
                if (loadStart)
                    next_state = pbfc_pkg::ST_LOAD;
                else if (storeStart && !storeBad)
                    next_state = pbfc_pkg::ST_STORE;
            pbfc_pkg::ST_LOAD:
                if (lastDig)
                    next_state = pbfc_pkg::ST_LFIN;
            pbfc_pkg::ST_LFIN:
                next_state = pbfc_pkg::ST_IDLE;
            pbfc_pkg::ST_STORE:
                if (storeLast)
                    next_state = pbfc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            state <= pbfc_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    localparam logic [4:0] IDX_LAST = 5'(pbfc_pkg::DEC_DIGITS - 1);

    // Load datapath: latch operand, accumulate digits, register the result
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            operand    <= '0;
            acc        <= '0;
            digitIdx   <= '0;
            loadDone   <= 1'b0;
            loadResult <= '0;
        end
        else
        begin
            loadDone <= (state == pbfc_pkg::ST_LFIN);
            if (state == pbfc_pkg::ST_IDLE && loadStart)
            begin
                operand  <= loadOperand;
                acc      <= '0;
                digitIdx <= IDX_LAST;
            end
            else if (state == pbfc_pkg::ST_LOAD)
            begin
                acc      <= accNext;
                digitIdx <= digitIdx - 5'h01;
            end
            if (state == pbfc_pkg::ST_LFIN)
                loadResult <= extWord;
        end
    end

    // Sign of the operand in flight; low seven bits of the last byte ignored
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            opSign <= 1'b0;
        else if (state == pbfc_pkg::ST_IDLE && loadStart)
            opSign <= loadOperand[pbfc_pkg::DEC_SIGN];
        else if (state == pbfc_pkg::ST_IDLE && storeStart)
            opSign <= storeSign;
    end

    // Store datapath: range check, then 64 double-dabble steps
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            bcdShift    <= '0;
            binShift    <= '0;
            bitCnt      <= '0;
            storeDone   <= 1'b0;
            storeResult <= '0;
        end
        else
        begin
            storeDone <= 1'b0;
            if (state == pbfc_pkg::ST_IDLE && !loadStart && storeStart)
            begin
                if (storeBad)
                begin
                    storeResult <= pbfc_pkg::DEC_INDEF;
                    storeDone   <= 1'b1;
                end
                binShift <= storeMagnitude;
                bcdShift <= '0;
                bitCnt   <= '0;
            end
            else if (state == pbfc_pkg::ST_STORE)
            begin
                bcdShift <= bcdNext;
                binShift <= binShift << 1;
                bitCnt   <= bitCnt + 7'h01;
                if (storeLast)
                begin
                    // Magnitude digits plus the sign alone; no complement form
                    storeResult <= {opSign, {pbfc_pkg::DEC_PAD_W{1'b0}}, bcdNext};
                    storeDone   <= 1'b1;
                end
            end
        end
    end

    // Busy mirrors a non-idle sequencer, registered from next_state so it tracks state with no lag
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            busy <= 1'b0;
        else
            busy <= (next_state != pbfc_pkg::ST_IDLE);
    end

    // Digit checker; unpacked high nibble is don't-care for add and subtract
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            gpHighDigit  <= '0;
            gpLowDigit   <= '0;
            gpUnpackedOk <= 1'b0;
            gpPackedOk   <= 1'b0;
        end
        else
        begin
            gpHighDigit  <= gpByte[7:4];
            gpLowDigit   <= gpByte[3:0];
            gpUnpackedOk <= lowOk && (!gpMulDiv || highZ);
            gpPackedOk   <= lowOk && highOk;
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    AST_LOAD_LATENCY: assert property (
        (state == pbfc_pkg::ST_IDLE && loadStart) |-> ##20 loadDone)
        else $error("load done not 20 cycles after start");
    AST_LOAD_SIGN: assert property (
        (state == pbfc_pkg::ST_IDLE && loadStart) |-> ##20
        (loadResult[79] == $past(loadOperand[pbfc_pkg::DEC_SIGN], 20)))
        else $error("load sign not carried");
    AST_LOAD_NORM: assert property (
        (loadDone && loadResult[78:64] != '0) |-> loadResult[pbfc_pkg::EXT_INT_BIT])
        else $error("nonzero load result not normalized");
    AST_LOAD_EXP_RANGE: assert property (
        (loadDone && loadResult[78:64] != '0) |->
        (loadResult[78:64] <= pbfc_pkg::EXT_BIAS + pbfc_pkg::EXT_TOP_POW))
        else $error("load exponent beyond 64-bit range");
    AST_LOAD_ZERO: assert property (
        (loadDone && !loadResult[pbfc_pkg::EXT_INT_BIT]) |-> (loadResult[78:0] == '0))
        else $error("unnormalized nonzero load result");
    AST_STORE_INDEF: assert property (
        (state == pbfc_pkg::ST_IDLE && !loadStart && storeStart && storeInvalid)
        |=> (storeDone && storeResult == pbfc_pkg::DEC_INDEF))
        else $error("invalid store did not give indefinite");
    AST_STORE_LATENCY: assert property (
        (state == pbfc_pkg::ST_IDLE && !loadStart && storeStart && !storeBad)
        |-> ##65 storeDone)
        else $error("store done not 65 cycles after start");
    AST_STORE_PAD: assert property (
        (storeDone && storeResult != pbfc_pkg::DEC_INDEF) |-> (storeResult[78:72] == '0))
        else $error("store pad bits not zero");
    AST_GP_MULDIV: assert property (
        (gpMulDiv && gpByte[7:4] != 4'h0) |=> !gpUnpackedOk)
        else $error("nonzero high nibble accepted for multiply");
    AST_GP_RANGE: assert property (
        (gpByte[3:0] > pbfc_pkg::DIGIT_MAX) |=> (!gpUnpackedOk && !gpPackedOk))
        else $error("digit above nine accepted");

    COV_LOAD_NEG: cover property (loadDone && loadResult[79]);
    COV_STORE_OK: cover property (storeDone && storeResult != pbfc_pkg::DEC_INDEF);
    COV_STORE_INDEF: cover property (storeDone && storeResult == pbfc_pkg::DEC_INDEF);
    COV_LOAD_ZERO: cover property (loadDone && !loadResult[pbfc_pkg::EXT_INT_BIT]);
endmodule : pbfc_converter

// *** pbfc_pkg.sv ***
// Shared constants for the packed decimal / floating-point converter.
// Assumes a single core clock; the memory path supplies whole 80-bit operands.
package pbfc_pkg;
    localparam int          DIGIT_W      = 4;    // One decimal digit per nibble
    localparam logic [3:0]  DIGIT_MAX    = 4'h9; // Largest legal digit value
    localparam int          DEC_DIGITS   = 18;   // Digits in the 10-byte decimal
    localparam int          DEC_W        = 80;   // Width of the 10-byte decimal
    localparam int          DEC_MAG_W    = 72;   // Digit field, bytes zero to eight
    localparam int          DEC_SIGN     = 79;   // Sign bit of the last byte
    localparam int          DEC_PAD_W    = 7;    // Ignored low bits of the last byte
    localparam int          BIN_W        = 64;   // Binary magnitude width
    localparam int          LZ_W         = 6;    // Leading-zero count width
    localparam int          CNT_W        = 7;    // Store bit counter width
    localparam int          IDX_W        = 5;    // Digit index width
    localparam logic [63:0] DEC_MAX      = 64'h0DE0B6B3A763FFFF; // Ten to the 18th less one
    localparam logic [79:0] DEC_INDEF    = 80'hFFFFC00000000000000; // Indefinite as printed
    localparam int          EXP_W        = 15;   // Extended exponent width
    localparam logic [14:0] EXT_BIAS     = 15'h3FFF; // 16383
    localparam logic [14:0] DBL_BIAS     = 15'h03FF; // 1023
    localparam logic [14:0] SGL_BIAS     = 15'h007F; // 127
    localparam int          EXT_INT_BIT  = 63;   // Explicit integer bit
    localparam int          EXT_FRAC_MSB = 62;   // Top fraction bit
    localparam logic [14:0] EXT_TOP_POW  = 15'h003F; // Power of the integer bit
    localparam logic [3:0]  DABBLE_LIM   = 4'h5; // Nibble limit before a shift
    localparam logic [3:0]  DABBLE_ADD   = 4'h3; // Correction added to a nibble
    localparam logic [6:0]  STORE_LAST   = 7'h3F; // Last store shift step

    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'h1,
        ST_LOAD  = 4'h2,
        ST_LFIN  = 4'h4,
        ST_STORE = 4'h8
    } pbfc_state_t;
endpackage : pbfc_pkg

// *** pbfc_normalizer.sv ***
// Leading-zero count and left shift of a binary magnitude.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module pbfc_normalizer
#(
    parameter int WIDTH = 64,
    parameter int LZW   = 6
)
(
    input  wire logic [WIDTH-1:0] magnitude,
    output logic      [WIDTH-1:0] shifted,
    output logic      [LZW-1:0]   leadZeros,
    output logic                  isZero
);
    logic found;

    // Scan from the top; the first one found fixes the shift
    always_comb
    begin
        leadZeros = '0;
        found     = 1'b0;
        for (int i = WIDTH - 1; i >= 0; i--)
        begin
            if (!found && magnitude[i])
            begin
                leadZeros = LZW'(WIDTH - 1 - i);
                found     = 1'b1;
            end
        end
        isZero  = !found;
        shifted = magnitude << leadZeros;
    end
endmodule : pbfc_normalizer

// *** pbfc_mem_model.sv ***
// Partner model: memory load/store path and sequencer feeding the converter.
// Assumes the bench calls one task at a time, all on the core clock.
`timescale 1ns/1ps
module pbfc_mem_model
(
    input  wire logic        clock,
    input  wire logic        loadDone,
    input  wire logic        storeDone,
    output logic             loadStart,
    output logic      [79:0] loadOperand,
    output logic             storeStart,
    output logic             storeInvalid,
    output logic             storeSign,
    output logic      [63:0] storeMagnitude
);
    // Idle levels at time zero
    initial
    begin
        loadStart      = 1'b0;
        loadOperand    = 80'h0;
        storeStart     = 1'b0;
        storeInvalid   = 1'b0;
        storeSign      = 1'b0;
        storeMagnitude = 64'h0;
    end

    // Load; pk 1 adds a same-cycle store, pk 2 pokes a store while busy
    task automatic doLoad(input logic [79:0] op, input int pk, output int lat);
        @(posedge clock);
        loadStart   <= 1'b1;
        loadOperand <= op;
        storeStart  <= (pk == 1);
        @(posedge clock);
        loadStart   <= 1'b0;
        storeStart  <= 1'b0;
        loadOperand <= ~op; // Stale once taken, so never left showing
        lat = 0;
        #1;
        while (loadDone !== 1'b1 && lat < 200)
        begin
            @(posedge clock);
            lat++;
            storeStart <= (lat == pk);
            #1;
        end
        storeStart <= 1'b0;
    endtask : doLoad

    // Store request; operand fields inverted once the request is taken
    task automatic doStore(input logic inv, input logic s, input logic [63:0] mag,
                           output int lat);
        @(posedge clock);
        storeStart     <= 1'b1;
        storeInvalid   <= inv;
        storeSign      <= s;
        storeMagnitude <= mag;
        @(posedge clock);
        storeStart     <= 1'b0;
        storeInvalid   <= ~inv;
        storeSign      <= ~s;
        storeMagnitude <= ~mag;
        lat = 0;
        #1;
        while (storeDone !== 1'b1 && lat < 200)
        begin
            @(posedge clock);
            lat++;
            #1;
        end
    endtask : doStore
endmodule : pbfc_mem_model

// *** tb_top.sv ***
// Self-checking bench for the decimal load/store converter.
// Assumes the partner model drives requests; expectations queue per path.
`timescale 1ns/1ps
module tb_top;
    logic        clock, resetn, gpMulDiv, gpOn, gpMdPrev;
    logic [7:0]  gpByte, gpPrev;
    logic        loadStart, storeStart, storeInvalid, storeSign;
    logic [79:0] loadOperand;
    logic [63:0] storeMagnitude;
    wire         busy, loadDone, storeDone, gpUnpackedOk, gpPackedOk;
    wire  [79:0] loadResult, storeResult;
    wire  [3:0]  gpHighDigit, gpLowDigit;
    logic [79:0] loadQ[$], storeQ[$];
    int          n_fail, tests_run, seed;

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    pbfc_converter pbfc_converter_i(.clock(clock), .resetn(resetn), .loadStart(loadStart),
        .loadOperand(loadOperand), .storeStart(storeStart), .storeInvalid(storeInvalid),
        .storeSign(storeSign), .storeMagnitude(storeMagnitude), .gpByte(gpByte),
        .gpMulDiv(gpMulDiv), .busy(busy), .loadDone(loadDone), .loadResult(loadResult),
        .storeDone(storeDone), .storeResult(storeResult), .gpHighDigit(gpHighDigit),
        .gpLowDigit(gpLowDigit), .gpUnpackedOk(gpUnpackedOk), .gpPackedOk(gpPackedOk));

    pbfc_mem_model pbfc_mem_model_i(.clock(clock), .loadDone(loadDone),
        .storeDone(storeDone), .loadStart(loadStart), .loadOperand(loadOperand),
        .storeStart(storeStart), .storeInvalid(storeInvalid), .storeSign(storeSign),
        .storeMagnitude(storeMagnitude));

    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    // Exact BCD to extended conversion, worked out digit by digit
    function automatic logic [79:0] expLoad(input logic [79:0] op);
        logic [63:0] acc;
        int          lz;
        acc = 64'h0;
        for (int i = 17; i >= 0; i--)
            acc = acc * 10 + 64'(op[i*4 +: 4]);
        if (acc == 64'h0)
            return {op[79], 79'h0};
        lz = 0;
        while (!acc[63])
        begin
            acc = acc << 1;
            lz++;
        end
        return {op[79], pbfc_pkg::EXT_BIAS + 15'(63 - lz), acc};
    endfunction : expLoad

    function automatic logic [79:0] expStore(input logic inv, input logic s,
                                             input logic [63:0] mag);
        logic [79:0] r;
        if (inv || mag > pbfc_pkg::DEC_MAX)
            return pbfc_pkg::DEC_INDEF;
        r = {s, 79'h0};
        for (int i = 0; i < 18; i++)
        begin
            r[i*4 +: 4] = 4'(mag % 10);
            mag = mag / 10;
        end
        return r;
    endfunction : expStore

    // Legal operands only: the path never offers bad digits or the indefinite
    function automatic logic [79:0] rndBcd();
        logic [79:0] op;
        op = 80'h0;
        for (int i = 0; i < 18; i++)
            op[i*4 +: 4] = 4'($unsigned($random(seed)) % 10);
        op[79:72] = 8'($random(seed));
        return op;
    endfunction : rndBcd

    // Digit checker stimulus; gpPrev mirrors what the design sampled
    always @(posedge clock)
    begin
        gpPrev   <= gpByte;
        gpMdPrev <= gpMulDiv;
        gpByte   <= 8'($random(seed));
        gpMulDiv <= 1'($random(seed));
    end

    // Result monitor: each done pops the oldest note of its path
    always @(negedge clock)
    begin
        // Sequencer is back at idle in the cycle that shows either done pulse
        if (loadDone === 1'b1 || storeDone === 1'b1)
            check(80'(busy), 80'h0);
        if (loadDone === 1'b1)
            if (loadQ.size() == 0) check(80'h1, 80'h0);
            else check(loadResult, loadQ.pop_front());
        if (storeDone === 1'b1)
            if (storeQ.size() == 0) check(80'h1, 80'h0);
            else check(storeResult, storeQ.pop_front());
        if (gpOn)
        begin
            check(80'({gpHighDigit, gpLowDigit}), 80'(gpPrev));
            check(80'(gpUnpackedOk), 80'(gpPrev[3:0] <= 4'h9 &&
                  (!gpMdPrev || gpPrev[7:4] == 4'h0)));
            check(80'(gpPackedOk), 80'(gpPrev[3:0] <= 4'h9 && gpPrev[7:4] <= 4'h9));
        end
    end

    initial
    begin
        logic [79:0] op;
        logic [63:0] mag;
        logic        inv;
        int          lat;
        seed = 32'h3304E5AD;
        resetn = 1'b0;
        gpOn = 1'b0;
        n_fail = 0;
        tests_run = 0;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        gpOn <= 1'b1;
        // Loads: signed zeros, all nines, one, random; stores refused alongside
        for (int i = 0; i < 24; i++)
        begin
            op = (i == 0) ? 80'h0 : (i == 1) ? {1'b1, 79'h0} :
                 (i == 2) ? {8'hFF, 72'h999999999999999999} : (i == 3) ? 80'h1 : rndBcd();
            loadQ.push_back(expLoad(op));
            pbfc_mem_model_i.doLoad(op, i % 3, lat);
            // Done is seen 19 edges after the taking edge
            check(80'(lat), 80'd19);
            if (lat >= 200) end_of_test();
        end
        // Stores: zero, range ends, invalid, random magnitudes
        for (int i = 0; i < 24; i++)
        begin
            inv = (i == 4);
            mag = (i == 0) ? 64'h0 : (i == 1) ? pbfc_pkg::DEC_MAX :
                  (i == 2) ? pbfc_pkg::DEC_MAX + 64'h1 : (i == 3) ? 64'h1 :
                  {32'($random(seed)), 32'($random(seed))} % (pbfc_pkg::DEC_MAX + 64'h1);
            storeQ.push_back(expStore(inv, i[0], mag));
            pbfc_mem_model_i.doStore(inv, i[0], mag, lat);
            check(80'(lat), (inv || mag > pbfc_pkg::DEC_MAX) ? 80'd0 : 80'd64);
            if (lat >= 200) end_of_test();
        end
        repeat (4) @(posedge clock);
        end_of_test();
    end
endmodule : tb_top
